// *** src/fws_pkg.sv ***
// Package for the flash write-status host controller
// Assumes a 125 MHz core clock and an asynchronous parallel flash on pins
package fws_pkg;
    localparam int DATA_W = 16;
    localparam int ADDR_W = 23;
    // Status bit positions on the data bus
    localparam int BIT_POLL = 7;
    localparam int BIT_TOG1 = 6;
    localparam int BIT_TOUT = 5;
    localparam int BIT_ETMR = 3;
    localparam int BIT_TOG2 = 2;
    localparam int BIT_BABT = 1;
    // Bus timing
    localparam int CLK_NS = 8;
    localparam int RD_NS = 90;
    localparam int RD_CYC = (RD_NS + CLK_NS - 1) / CLK_NS;
    localparam int WR_NS = 40;
    localparam int WR_CYC = (WR_NS + CLK_NS - 1) / CLK_NS;
    localparam int GAP_CYC = 2;
    localparam int ERASE_GAP_US = 50;
    localparam int ERASE_GAP_CYC = ERASE_GAP_US * 1000 / CLK_NS;
    // Command words
    localparam logic [15:0] CMD_RESET = 16'h00F0;
    localparam logic [15:0] CMD_UNLK1 = 16'h00AA;
    localparam logic [15:0] CMD_UNLK2 = 16'h0055;
    localparam logic [15:0] CMD_ABRST = 16'h00F0;
    localparam logic [22:0] ADR_UNLK1 = 23'h00_0555;
    localparam logic [22:0] ADR_UNLK2 = 23'h00_02AA;
    // Operation codes on the user port
    localparam logic [2:0] OP_WRITE = 3'h0;
    localparam logic [2:0] OP_READ = 3'h1;
    localparam logic [2:0] OP_POLL = 3'h2;
    localparam logic [2:0] OP_ETMR = 3'h3;
    localparam logic [2:0] OP_RESET = 3'h4;
    localparam logic [2:0] OP_ABRST = 3'h5;
    // Poll outcome
    typedef enum logic [2:0] {
        RES_OK = 3'h0,
        RES_TIMEOUT = 3'h1,
        RES_ABORT = 3'h2,
        RES_ETMR_LO = 3'h3,
        RES_ETMR_HI = 3'h4
    } fws_res_t;
    typedef struct packed {
        logic [2:0] op;
        logic [22:0] addr;
        logic [15:0] data;
    } fws_req_t;
    typedef struct packed {
        logic ce_n;
        logic oe_n;
        logic we_n;
    } fws_ctl_t;
endpackage

// *** src/fws_host.sv ***
// Host controller that drives a parallel NOR flash and decodes its write status
// Assumes the flash pins are wired directly; data in and ready/busy are asynchronous
`default_nettype none
module fws_host
    import fws_pkg::*;
(
    input wire logic core_clk_i,             // 125 MHz clock
    input wire logic srst_i,                 // Sync reset, high
    input wire fws_req_t req_i,              // Operation request
    input wire logic req_valid_i,            // Request strobe
    output logic req_ready_o,                // Idle, can take request
    output logic done_o,                     // Operation finished pulse
    output fws_res_t res_o,                  // Poll outcome
    output logic [DATA_W-1:0] rdata_o,       // Last read word
    output logic ready_o,                    // Synced ready/busy level
    output logic [ADDR_W-1:0] fl_addr_o,     // Flash address
    output fws_ctl_t fl_ctl_o,               // Chip, output, write enables (low)
    input wire logic [DATA_W-1:0] fl_dq_i,   // Flash data in
    output logic [DATA_W-1:0] fl_dq_o,       // Flash data out
    output logic fl_dq_oe_o,                 // High while host drives data
    input wire logic fl_rdy_i                // Ready/busy pin
);
    typedef enum logic [6:0] {
        S_IDLE = 7'b0000001,
        S_WR = 7'b0000010,
        S_RD = 7'b0000100,
        S_GAP = 7'b0001000,
        S_EVAL = 7'b0010000,
        S_DONE = 7'b0100000,
        S_NEXT = 7'b1000000
    } fws_st_t;

    // ==========================================
    // Input synchronisers
    logic [DATA_W-1:0] dq_m, dq_s;
    logic rdy_m, rdy_s;
    always_ff @(posedge core_clk_i) begin
        dq_m <= fl_dq_i;
        dq_s <= dq_m;
        rdy_m <= fl_rdy_i;
        rdy_s <= rdy_m;
    end
    assign ready_o = rdy_s;

    // ==========================================
    // Sequencer
    fws_st_t st, next_st;
    fws_req_t cur, next_cur;
    logic [7:0] cnt, next_cnt;
    logic [1:0] step, next_step;
    logic [1:0] nrd, next_nrd;
    logic [DATA_W-1:0] prev, next_prev, rdata, next_rdata;
    fws_res_t res, next_res;
    logic [ADDR_W-1:0] addr, next_addr;
    logic [DATA_W-1:0] wdat, next_wdat;
    fws_ctl_t ctl, next_ctl;
    logic oe, next_oe;
    logic tout_seen, next_tout_seen;
    logic toggling;

    assign toggling = prev[BIT_TOG1] != rdata[BIT_TOG1];

    always_comb begin
        next_st = st;
        next_cur = cur;
        next_cnt = cnt;
        next_step = step;
        next_nrd = nrd;
        next_prev = prev;
        next_rdata = rdata;
        next_res = res;
        next_addr = addr;
        next_wdat = wdat;
        next_ctl = ctl;
        next_oe = oe;
        next_tout_seen = tout_seen;
        case (st)
            S_IDLE: begin
                next_ctl = '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
                next_oe = 1'b0;
                if (req_valid_i) begin
                    next_cur = req_i;
                    next_step = 2'd0;
                    next_nrd = 2'd0;
                    next_tout_seen = 1'b0;
                    next_res = RES_OK;
                    next_cnt = 8'd0;
                    next_addr = req_i.addr;
                    if (req_i.op == OP_WRITE) begin
                        next_wdat = req_i.data;
                        next_st = S_WR;
                    end else if (req_i.op == OP_RESET) begin
                        next_wdat = CMD_RESET;
                        next_st = S_WR;
                    end else if (req_i.op == OP_ABRST) begin
                        next_addr = ADR_UNLK1;
                        next_wdat = CMD_UNLK1;
                        next_st = S_WR;
                    end else begin
                        next_st = S_RD;
                    end
                end
            end
            S_WR: begin
                next_ctl = '{ce_n: 1'b0, oe_n: 1'b1, we_n: 1'b0};
                next_oe = 1'b1;
                next_cnt = cnt + 8'd1;
                if (cnt == 8'(WR_CYC - 1)) begin
                    next_cnt = 8'd0;
                    next_st = S_NEXT;
                end
            end
            S_NEXT: begin
                next_ctl = '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
                next_cnt = cnt + 8'd1;
                if (cnt == 8'(GAP_CYC - 1)) begin
                    next_cnt = 8'd0;
                    next_oe = 1'b0;
                    if (cur.op == OP_ABRST && step != 2'd2) begin
                        next_step = step + 2'd1;
                        next_st = S_WR;
                        next_addr = (step == 2'd0) ? ADR_UNLK2 : ADR_UNLK1;
                        next_wdat = (step == 2'd0) ? CMD_UNLK2 : CMD_ABRST;
                    end else begin
                        next_st = S_DONE;
                    end
                end
            end
            S_RD: begin
                next_ctl = '{ce_n: 1'b0, oe_n: 1'b0, we_n: 1'b1};
                next_cnt = cnt + 8'd1;
                // Two sync stages added to the access time
                if (cnt == 8'(RD_CYC + 2)) begin
                    next_cnt = 8'd0;
                    next_prev = rdata;
                    next_rdata = dq_s;
                    if (nrd != 2'd3) begin
                        next_nrd = nrd + 2'd1;
                    end
                    next_st = S_GAP;
                end
            end
            S_GAP: begin
                next_ctl = '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
                next_cnt = cnt + 8'd1;
                if (cnt == 8'(GAP_CYC - 1)) begin
                    next_cnt = 8'd0;
                    next_st = S_EVAL;
                end
            end
            S_EVAL: begin
                next_st = S_RD;
                if (cur.op == OP_READ) begin
                    next_st = S_DONE;
                end else if (cur.op == OP_ETMR) begin
                    // Timer flag read after two status reads; toggling is not checked
                    if (nrd >= 2'd2) begin
                        next_res = rdata[BIT_ETMR] ? RES_ETMR_HI : RES_ETMR_LO;
                        next_st = S_DONE;
                    end
                end else if (nrd >= 2'd2) begin
                    if (!toggling) begin
                        next_res = RES_OK;
                        next_st = S_DONE;
                    end else if (tout_seen) begin
                        // Flag seen on two toggling reads decides the failure
                        next_tout_seen = 1'b0;
                        if (rdata[BIT_BABT]) begin
                            next_res = RES_ABORT;
                            next_st = S_DONE;
                        end else if (rdata[BIT_TOUT]) begin
                            next_res = RES_TIMEOUT;
                            next_st = S_DONE;
                        end
                    end else if (rdata[BIT_TOUT] || rdata[BIT_BABT]) begin
                        // First array word may look like a flag; recheck toggle once more
                        next_tout_seen = 1'b1;
                    end
                end
            end
            S_DONE: begin
                next_st = S_IDLE;
            end
            default: begin
                next_st = S_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            st <= S_IDLE;
            cur <= '0;
            cnt <= 8'd0;
            step <= 2'd0;
            nrd <= 2'd0;
            prev <= '0;
            rdata <= '0;
            res <= RES_OK;
            addr <= '0;
            wdat <= '0;
            ctl <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
            oe <= 1'b0;
            tout_seen <= 1'b0;
        end else begin
            st <= next_st;
            cur <= next_cur;
            cnt <= next_cnt;
            step <= next_step;
            nrd <= next_nrd;
            prev <= next_prev;
            rdata <= next_rdata;
            res <= next_res;
            addr <= next_addr;
            wdat <= next_wdat;
            ctl <= next_ctl;
            oe <= next_oe;
            tout_seen <= next_tout_seen;
        end
    end

    assign req_ready_o = (st == S_IDLE);
    assign done_o = (st == S_DONE);
    assign res_o = res;
    assign rdata_o = rdata;
    assign fl_addr_o = addr;
    assign fl_ctl_o = ctl;
    assign fl_dq_o = wdat;
    assign fl_dq_oe_o = oe;

    // ==========================================
    // Assertions
    no_rw_clash_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
        !(fl_ctl_o.oe_n == 1'b0 && fl_dq_oe_o)) else $error("Host drives data during read");
    we_width_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
        $fell(fl_ctl_o.we_n) |-> !fl_ctl_o.we_n [*5]) else $error("Write pulse too short");
    tout_res_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
        (done_o && res_o == RES_TIMEOUT) |-> rdata_o[BIT_TOUT]) else $error("Timeout result without flag");
    abort_res_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
        (done_o && res_o == RES_ABORT) |-> rdata_o[BIT_BABT]) else $error("Abort result without flag");
    etmr_res_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
        (done_o && res_o == RES_ETMR_HI) |-> rdata_o[BIT_ETMR]) else $error("Timer result mismatch");
    ok_stable_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
        (done_o && cur.op == OP_POLL && res_o == RES_OK) |-> !toggling) else $error("Done while toggling");
    done_pulse_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
        done_o |=> !done_o ##0 req_ready_o) else $error("Done not single pulse");
    rd_strobe_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
        $fell(fl_ctl_o.oe_n) |-> fl_ctl_o.we_n ##1 !fl_ctl_o.oe_n [*8]) else $error("Read strobe too short");
    c_tout: cover property (@(posedge core_clk_i) done_o && res_o == RES_TIMEOUT);
    c_abort: cover property (@(posedge core_clk_i) done_o && res_o == RES_ABORT);
    c_etmr: cover property (@(posedge core_clk_i) done_o && res_o == RES_ETMR_HI);
endmodule
`default_nettype wire

// *** verification/fws_flash_model.sv ***
// Behavioural parallel flash seen by the host controller: status bits and ready/busy
// Assumes the host pins are wired straight across; times in ns, the part has no clock
`default_nettype none
module fws_flash_model
    import fws_pkg::*;
#(
    parameter realtime PRG_T = 2000,
    parameter realtime WIN_T = 3000,
    parameter realtime ERS_T = 3000
) (
    input wire logic [ADDR_W-1:0] addr_i,  // Address pins
    input wire fws_ctl_t ctl_i,            // Strobes, low active
    input wire logic [DATA_W-1:0] dq_i,    // Data from host
    output logic [DATA_W-1:0] dq_o,        // Data to host
    output logic rdy_o                     // Ready/busy, pulled up
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [DATA_W-1:0] mem [64];
    logic armed = 1'b0;
    logic fail = 1'b0;
    logic abrt = 1'b0;
    logic tog = 1'b0;
    logic [5:0] pa = '0;
    realtime t_prg = -1e6;
    realtime t_ers = -1e6;
    function automatic logic prg_b();
        return $realtime < t_prg + PRG_T;
    endfunction
    function automatic logic win_b();
        return $realtime < t_ers + WIN_T;
    endfunction
    function automatic logic ers_b();
        return $realtime < t_ers + WIN_T + ERS_T;
    endfunction
    initial begin
        foreach (mem[i]) mem[i] = '1;
        dq_o = '0;
        rdy_o = 1'b1;
    end
    // ==========================================
    // Command decode
    always @(posedge ctl_i.we_n) begin
        if (!(ers_b() && !win_b())) begin
            if (armed) begin
                armed = 1'b0;
                pa = addr_i[5:0];
                if (|(dq_i & ~mem[pa])) fail = 1'b1;
                else begin
                    mem[pa] = dq_i;
                    t_prg = $realtime;
                end
            end else if (dq_i == 16'h00A0) armed = 1'b1;
            else if (dq_i == 16'h0030) begin
                t_ers = $realtime;
                foreach (mem[i]) mem[i] = '1;
            end else if (dq_i == 16'h0025) abrt = 1'b1;
            else if (dq_i == CMD_RESET) begin
                fail = 1'b0;
                abrt = 1'b0;
            end
        end
    end
    // ==========================================
    // Read cycles
    always @(negedge ctl_i.oe_n) begin
        if (fail || abrt || prg_b() || ers_b()) begin
            tog = ~tog;
            dq_o = '0;
            dq_o[BIT_TOG1] = tog;
            dq_o[BIT_POLL] = ers_b() ? 1'b0 : ~mem[pa][BIT_POLL];
            dq_o[BIT_TOUT] = fail;
            dq_o[BIT_ETMR] = ers_b() && !win_b();
            dq_o[BIT_TOG2] = ers_b() && tog;
            dq_o[BIT_BABT] = abrt;
        end else dq_o = mem[addr_i[5:0]];
    end
    // Released bus shows no stale data
    always @(posedge ctl_i.oe_n) dq_o = ~dq_o;
    always #4 rdy_o = !(fail || abrt || prg_b() || ers_b());
endmodule
`default_nettype wire

// *** verification/flash_write_status_reporting_tb_top.sv ***
// Bench for the flash host controller against the behavioural flash
// Assumes the package constants and the model's default timers
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
    $display("wrong value at %0t: got %h expected %h", $time, (g), (e)); end end
module flash_write_status_reporting_tb_top
    import fws_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'b0;
    logic srst = 1'b1;
    logic req_valid = 1'b0;
    fws_req_t req = '0;
    logic req_ready, done, ready, dq_oe, rdy;
    fws_res_t res;
    logic [DATA_W-1:0] rdata, dq_h, dq_f;
    logic [ADDR_W-1:0] fa;
    fws_ctl_t ctl;
    int n_mismatch = 0;
    int cmp_count = 0;
    initial begin
        forever #4 core_clk = ~core_clk;
    end
    fws_host i_fws_host (.core_clk_i(core_clk), .srst_i(srst), .req_i(req), .req_valid_i(req_valid),
        .req_ready_o(req_ready), .done_o(done), .res_o(res), .rdata_o(rdata), .ready_o(ready), .fl_addr_o(fa),
        .fl_ctl_o(ctl), .fl_dq_i(dq_f), .fl_dq_o(dq_h), .fl_dq_oe_o(dq_oe), .fl_rdy_i(rdy));
    fws_flash_model i_fws_flash_model (.addr_i(fa), .ctl_i(ctl), .dq_i(dq_h), .dq_o(dq_f), .rdy_o(rdy));
    // ==========================================
    // Access tasks
    task automatic op(input logic [2:0] o, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        int n;
        n = 0;
        @(negedge core_clk);
        req = '{op: o, addr: a, data: d};
        req_valid = 1'b1;
        @(negedge core_clk);
        req_valid = 1'b0;
        while (done !== 1'b1 && n < 5000) begin
            @(negedge core_clk);
            n++;
        end
        `CHK(n < 5000, 1'b1)
    endtask
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        op(OP_WRITE, a, d);
    endtask
    task automatic unlock();
        wr(ADR_UNLK1, CMD_UNLK1);
        wr(ADR_UNLK2, CMD_UNLK2);
    endtask
    task automatic prog(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        unlock();
        wr(ADR_UNLK1, 16'h00A0);
        wr(a, d);
    endtask
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge core_clk);
        n_mismatch++;
        end_sim();
    end
    // ==========================================
    // Tests
    initial begin
        repeat (6) @(negedge core_clk);
        srst = 1'b0;
        `CHK(req_ready, 1'b1)
        `CHK(ctl, 3'h7)
        `CHK(dq_oe, 1'b0)
        $display("test reset done");
        prog(23'h00_000A, 16'h1234);
        // Ready/busy passes two sync stages after the last write pulse
        repeat (2) @(negedge core_clk);
        `CHK(ready, 1'b0)
        op(OP_READ, 23'h00_000A, '0);
        `CHK(rdata[BIT_POLL], 1'b1)
        op(OP_POLL, 23'h00_000A, '0);
        `CHK(res, RES_OK)
        `CHK(ready, 1'b1)
        op(OP_READ, 23'h00_000A, '0);
        `CHK(rdata, 16'h1234)
        $display("test program done");
        prog(23'h00_000A, 16'h1235);
        op(OP_POLL, 23'h00_000A, '0);
        `CHK(res, RES_TIMEOUT)
        op(OP_RESET, '0, '0);
        op(OP_READ, 23'h00_000A, '0);
        `CHK(rdata, 16'h1234)
        $display("test timeout done");
        unlock();
        wr(ADR_UNLK1, 16'h0080);
        unlock();
        wr('0, 16'h0030);
        op(OP_ETMR, '0, '0);
        `CHK(res, RES_ETMR_LO)
        repeat (200) @(negedge core_clk);
        wr('0, 16'h0030);
        repeat (250) @(negedge core_clk);
        op(OP_ETMR, '0, '0);
        `CHK(res, RES_ETMR_LO)
        repeat (300) @(negedge core_clk);
        op(OP_ETMR, '0, '0);
        `CHK(res, RES_ETMR_HI)
        op(OP_READ, '0, '0);
        `CHK(rdata[BIT_POLL], 1'b0)
        prog(23'h00_000A, 16'h0000);
        op(OP_POLL, '0, '0);
        `CHK(res, RES_OK)
        op(OP_READ, 23'h00_000A, '0);
        `CHK(rdata, 16'hFFFF)
        $display("test erase done");
        unlock();
        wr(23'h00_000A, 16'h0025);
        op(OP_POLL, 23'h00_000A, '0);
        `CHK(res, RES_ABORT)
        op(OP_ABRST, '0, '0);
        op(OP_READ, 23'h00_000A, '0);
        `CHK(rdata, 16'hFFFF)
        $display("test abort done");
        end_sim();
    end
endmodule
`default_nettype wire
